// File: hdl/dsr_cfg.svh
// Constants for the diagnostic shadow register
`ifndef DSR_CFG_SVH
`define DSR_CFG_SVH
`define DSR_WIDTH      8
`define DSR_MSB        7
`define DSR_RESET_VAL  8'h00
`define DSR_SYNC_STAGES 2
`endif

// File: hdl/dsr_pkg.sv
// Types for the diagnostic shadow register
`include "dsr_cfg.svh"
package dsr_pkg;
   typedef logic [`DSR_MSB:0] dsr_byte_type;
   // Operation chosen in a cycle, one-hot
   typedef enum logic [5:0] {
      DSR_OP_IDLE  = 6'h01,
      DSR_OP_LOAD  = 6'h02,
      DSR_OP_SHIFT = 6'h04,
      DSR_OP_COPY  = 6'h08,
      DSR_OP_CAPT  = 6'h10,
      DSR_OP_WBACK = 6'h20
   } dsr_op_type;
endpackage

// File: hdl/dsr_edge_if.sv
// Edge pulses passed from the edge finder to the register core
`timescale 1ns/1ns
`default_nettype none
interface dsr_edge_if;
   logic mainRise;   // Main clock rose
   logic shadowRise; // Shadow clock rose
   modport source (output mainRise, output shadowRise);
   modport sink   (input mainRise, input shadowRise);
endinterface
`default_nettype wire

// File: hdl/dsr_edge_detect.sv
// Synchroniser and rising-edge finder for the two outside clocks
`timescale 1ns/1ns
`default_nettype none
module dsr_edge_detect (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic arst_n,
   // Outside clock pins
   input  wire logic mainClkPin,
   input  wire logic shadowClkPin,
   // Edge pulses
   dsr_edge_if.source edges
);
   logic [1:0] mainSync_r;   // Two-stage synchroniser, main clock
   logic [1:0] shadowSync_r; // Two-stage synchroniser, shadow clock
   logic       mainLast_r;   // Previous synced main level
   logic       shadowLast_r; // Previous synced shadow level

   // ==========================================
   // Synchronise and delay
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         mainSync_r   <= 2'h0;
         shadowSync_r <= 2'h0;
         mainLast_r   <= 1'h0;
         shadowLast_r <= 1'h0;
      end else begin
         mainSync_r   <= {mainSync_r[0], mainClkPin};
         shadowSync_r <= {shadowSync_r[0], shadowClkPin};
         mainLast_r   <= mainSync_r[1];
         shadowLast_r <= shadowSync_r[1];
      end
   end

   // Rising edges, one-cycle pulses
   assign edges.mainRise   = mainSync_r[1] & ~mainLast_r;
   assign edges.shadowRise = shadowSync_r[1] & ~shadowLast_r;
endmodule
`default_nettype wire

// File: hdl/dsr_diag_register.sv
// Eight-bit output register with serial shadow register for diagnostics
// What this block does
// - Mode low, main rise: output loads input bus
// - Mode low, shadow rise: shadow shifts, serial in
// - Both rise, mode low: load and shift
// - Mode high, main rise: output takes shadow
// - Mode high, serial low: shadow captures bus
// - Mode high, serial low, both: swap
// - Mode high, serial high: drive shadow out
// - Disabled output bus acts as input
`timescale 1ns/1ns
`include "dsr_cfg.svh"
`default_nettype none
module dsr_diag_register (
   // Clock and reset
   input  wire logic                   ref_clk,
   input  wire logic                   arst_n,
   // Outside clocks and controls
   input  wire logic                   main_clock,
   input  wire logic                   shadow_shift_clock,
   input  wire logic                   mode,
   input  wire logic                   serial_diag_in,
   output logic                        serial_diag_out,
   // Input bus, two-way
   input  wire logic [`DSR_MSB:0]      input_bus_in,
   output logic [`DSR_MSB:0]           input_bus_out,
   output logic                        input_bus_oe_n,
   // Output bus, two-way
   input  wire logic [`DSR_MSB:0]      output_bus_in,
   input  wire logic                   output_bus_en_n,
   output logic [`DSR_MSB:0]           output_bus_out,
   output logic                        output_bus_oe_n
);
   // ==========================================
   // Edge finding
   // Pin edges closer together than one system clock can be lost,
   // so the controller must keep each clock phase well above that
   dsr_edge_if edges ();

   dsr_edge_detect u_edge (
      .ref_clk      (ref_clk),
      .arst_n       (arst_n),
      .mainClkPin   (main_clock),
      .shadowClkPin (shadow_shift_clock),
      .edges        (edges.source)
   );

   // ==========================================
   // Synchronise level inputs
   logic [1:0]          modeSync_r;    // Mode synchroniser
   logic [1:0]          serInSync_r;   // Serial input synchroniser
   logic [1:0]          busEnSync_r;   // Output-bus enable synchroniser
   dsr_pkg::dsr_byte_type inBus1_r;    // Input bus, stage one
   dsr_pkg::dsr_byte_type inBus2_r;    // Input bus, stage two
   dsr_pkg::dsr_byte_type outBus1_r;   // Output bus, stage one
   dsr_pkg::dsr_byte_type outBus2_r;   // Output bus, stage two

   // Two stages on every outside level before any logic reads it
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         modeSync_r  <= 2'h0;
         serInSync_r <= 2'h0;
         busEnSync_r <= 2'h3;
         inBus1_r    <= `DSR_RESET_VAL;
         inBus2_r    <= `DSR_RESET_VAL;
         outBus1_r   <= `DSR_RESET_VAL;
         outBus2_r   <= `DSR_RESET_VAL;
      end else begin
         modeSync_r  <= {modeSync_r[0], mode};
         serInSync_r <= {serInSync_r[0], serial_diag_in};
         busEnSync_r <= {busEnSync_r[0], output_bus_en_n};
         inBus1_r    <= input_bus_in;
         inBus2_r    <= inBus1_r;
         outBus1_r   <= output_bus_in;
         outBus2_r   <= outBus1_r;
      end
   end

   // Synced levels
   // busOff high means our own output drivers are off
   wire modeS  = modeSync_r[1];
   wire serInS = serInSync_r[1];
   wire busOff = busEnSync_r[1];

   // ==========================================
   // Register state
   // Both registers are plain flip-flops that run on every clock
   dsr_pkg::dsr_byte_type outReg_r;    // Output register
   dsr_pkg::dsr_byte_type outReg_nxt;  // Its next value
   dsr_pkg::dsr_byte_type shadow_r;    // Shadow register
   dsr_pkg::dsr_byte_type shadow_nxt;  // Its next value

   // Value seen on the output bus: pins when off, own register otherwise
   // With our drivers on, the pins only echo outReg_r, so it is read directly
   // and the old value is used even in the cycle of a swap
   wire [`DSR_MSB:0] busSeen = busOff ? outBus2_r : outReg_r;

   // Decoded operations
   // Edge pulses and levels both lag the pins by two clocks, so levels set
   // before the pin edge have settled when its pulse arrives
   wire mainR   = edges.mainRise;
   wire shadR   = edges.shadowRise;
   wire loadIn  = ~modeS & mainR;
   wire shiftSh = ~modeS & shadR;
   wire copySh  = modeS & mainR;
   wire captBus = modeS & ~serInS & shadR;
   wire wback   = modeS & serInS & shadR & ~mainR;

   // Next output register; swap takes the old shadow value
   // Load needs mode low and copy mode high, so the two never meet
   assign outReg_nxt = loadIn ? inBus2_r :
                       copySh ? shadow_r : outReg_r;

   // Next shadow register
   assign shadow_nxt = shiftSh ? {shadow_r[`DSR_MSB-1:0], serInS} :
                       captBus ? busSeen : shadow_r;

   // ==========================================
   // Update registers
   // Reset values are a convenience only; load before relying on them
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         outReg_r <= `DSR_RESET_VAL;
         shadow_r <= `DSR_RESET_VAL;
      end else begin
         outReg_r <= outReg_nxt;
         shadow_r <= shadow_nxt;
      end
   end

   // ==========================================
   // Write-back drive state, held until the mode or serial input leaves
   logic wbOn_r; // Input bus driven with shadow contents
   // A main edge in the same cycle is taken as a copy, so no drive then
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wbOn_r <= 1'h0;
      end else if (wback) begin
         wbOn_r <= 1'h1;
      end else if (!(modeS & serInS)) begin
         wbOn_r <= 1'h0;
      end
   end

   // Serial out: bit 7 in mode low, pass-through in mode high
   // A mux of two flip-flops; pass-through still lags serial_diag_in by the two synchroniser stages
   assign serial_diag_out = modeS ? serInS : shadow_r[`DSR_MSB];

   // Pin drives; enables low while driving
   // The shadow always sits on input_bus_out; only the enable decides
   assign input_bus_out   = shadow_r;
   assign input_bus_oe_n  = ~wbOn_r;
   assign output_bus_out  = outReg_r;
   assign output_bus_oe_n = busOff;

   // ==========================================
   // Checks
   // Each check but a_serial_out and a_drive_start looks one clock past its trigger, where the update lands
   a_load_output: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (~modeS & mainR) |=> (outReg_r == $past(inBus2_r)))
      else $error("output register missed input bus load");
   a_shift_shadow: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (~modeS & shadR) |=> (shadow_r == {$past(shadow_r[6:0]), $past(serInS)}))
      else $error("shadow shift wrong");
   a_both_lowmode: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (~modeS & mainR & shadR) |=> (outReg_r == $past(inBus2_r)
      && shadow_r == {$past(shadow_r[6:0]), $past(serInS)}))
      else $error("combined load and shift wrong");
   a_copy_shadow: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (modeS & mainR & ~shadR) |=> (outReg_r == $past(shadow_r)
      && $stable(shadow_r)))
      else $error("copy from shadow wrong");
   a_capture_bus: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (modeS & ~serInS & shadR & ~mainR) |=> (shadow_r == $past(busSeen)
      && $stable(outReg_r)))
      else $error("bus capture wrong");
   a_swap_regs: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (modeS & ~serInS & shadR & mainR) |=> (outReg_r == $past(shadow_r)
      && shadow_r == $past(busSeen)))
      else $error("swap wrong");
   a_write_back: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (modeS & serInS & shadR & ~mainR) |=> (!input_bus_oe_n
      && $stable(shadow_r) && $stable(outReg_r)))
      else $error("write-back drive wrong");
   a_hold_idle: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (~mainR & ~shadR) |=> ($stable(outReg_r) && $stable(shadow_r)))
      else $error("register changed without an edge");
   a_serial_out: assert property (@(posedge ref_clk) disable iff (!arst_n)
      ~modeS |-> (serial_diag_out == shadow_r[7]))
      else $error("serial out not shadow bit 7");

   // Main clock alone leaves the shadow register untouched
   a_main_only: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (mainR & ~shadR) |=> $stable(shadow_r))
      else $error("shadow changed on a main edge alone");

   // Shadow clock alone leaves the output register untouched
   a_shadow_only: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (shadR & ~mainR) |=> $stable(outReg_r))
      else $error("output register changed on a shadow edge alone");

   // Disabled drivers: shadow captures the pins, not our own register
   a_pin_capture: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (captBus & busOff) |=> (shadow_r == $past(outBus2_r)))
      else $error("capture did not take the output bus pins");

   // Drive on the input bus starts only after a write-back edge
   a_drive_start: assert property (@(posedge ref_clk) disable iff (!arst_n)
      $fell(input_bus_oe_n) |-> $past(wback))
      else $error("input bus driven without write-back");

   // Drive ends once mode or serial input has left the high level
   a_drive_stop: assert property (@(posedge ref_clk) disable iff (!arst_n)
      !(modeS & serInS) |=> input_bus_oe_n)
      else $error("input bus still driven after write-back ended");

   // Edge pulses last one clock, so one pin edge acts once
   a_main_pulse: assert property (@(posedge ref_clk) disable iff (!arst_n)
      mainR |=> !mainR)
      else $error("main edge pulse longer than one clock");
   a_shadow_pulse: assert property (@(posedge ref_clk) disable iff (!arst_n)
      shadR |=> !shadR)
      else $error("shadow edge pulse longer than one clock");
endmodule
`default_nettype wire

// File: testbench/dsr_far_side.sv
// Far side model: data bus and diagnostic bus resolving the two-way pins
`timescale 1ns/1ns
`default_nettype none
module dsr_far_side (
   // Block's pin drivers
   input  wire logic [7:0] dOut,
   input  wire logic       dOeN,
   input  wire logic [7:0] bOut,
   input  wire logic       bOeN,
   // Values the far side puts on the buses
   input  wire logic [7:0] dDrv,
   input  wire logic [7:0] bDrv,
   // Resolved pin levels
   output logic [7:0]      dPin,
   output logic [7:0]      bPin
);
   // Block drives the input bus on write-back, the store releases it
   assign dPin = !dOeN ? dOut : dDrv;
   // Disabled drivers let the far side drive the output bus
   assign bPin = !bOeN ? bOut : bDrv;
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the diagnostic shadow register
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic ref_clk = 1'h0, arst_n = 1'h0, mClk = 1'h0, sClk = 1'h0, mode = 1'h0, sIn = 1'h0;
   logic enN = 1'h0;                            // Output bus drivers enabled
   dsr_pkg::dsr_byte_type dDrv = 8'h00, bDrv = 8'h00, dPin, bPin, dOut, bOut;
   logic sOut, dOeN, bOeN;
   int miscompares = 0, samplesChecked = 0;
   // ==========================
   // Clock and design
   always #5 ref_clk = ~ref_clk;
   dsr_far_side far (.dOut(dOut), .dOeN(dOeN), .bOut(bOut), .bOeN(bOeN),
      .dDrv(dDrv), .bDrv(bDrv), .dPin(dPin), .bPin(bPin));
   dsr_diag_register dut (.ref_clk(ref_clk), .arst_n(arst_n), .main_clock(mClk),
      .shadow_shift_clock(sClk), .mode(mode), .serial_diag_in(sIn),
      .serial_diag_out(sOut), .input_bus_in(dPin), .input_bus_out(dOut),
      .input_bus_oe_n(dOeN), .output_bus_in(bPin), .output_bus_en_n(enN),
      .output_bus_out(bOut), .output_bus_oe_n(bOeN));
   // ==========================
   // Shared tasks
   task automatic chk(input dsr_pkg::dsr_byte_type seen, input dsr_pkg::dsr_byte_type exp);
      samplesChecked++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One 160 ns link period: 40 ns setup, 80 ns high, 40 ns low; unused clock stays low
   task automatic op(input logic md, input logic si, input logic m, input logic s);
      mode <= md;
      sIn <= si;
      repeat (4) @(posedge ref_clk);
      mClk <= m;
      sClk <= s;
      repeat (8) @(posedge ref_clk);
      mClk <= 1'h0;
      sClk <= 1'h0;
      repeat (4) @(posedge ref_clk);
   endtask
   task automatic finalReport;
      $display("compares %0d mismatches %0d", samplesChecked, miscompares);
      if (miscompares == 0 && samplesChecked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ==========================
   // Scenarios
   task automatic hold_and_load;
      dDrv <= 8'h5a;
      repeat (20) @(posedge ref_clk);
      chk(bOut, 8'h00);
      chk({7'h00, bOeN}, 8'h00);
      op(1'h0, 1'h1, 1'h1, 1'h0);
      chk(bOut, 8'h5a);
      chk(dOut, 8'h00);
      chk({7'h00, sOut}, 8'h00);
   endtask
   task automatic shift_in;
      for (int i = 7; i >= 0; i--)
         op(1'h0, 1'(8'hc3 >> i), 1'h0, 1'h1);
      chk(dOut, 8'hc3);
      chk({7'h00, sOut}, 8'h01);
      chk(bOut, 8'h5a);
   endtask
   task automatic load_and_shift;
      dDrv <= 8'h96;
      op(1'h0, 1'h1, 1'h1, 1'h1);
      chk(bOut, 8'h96);
      chk(dOut, 8'h87);
   endtask
   task automatic copy_out;
      op(1'h1, 1'h0, 1'h1, 1'h0);
      chk(bOut, 8'h87);
      chk(dOut, 8'h87);
      chk({7'h00, sOut}, 8'h00);
      sIn <= 1'h1;
      repeat (5) @(posedge ref_clk);
      chk({7'h00, sOut}, 8'h01);
   endtask
   task automatic capture_and_swap;
      enN <= 1'h1;
      bDrv <= 8'h3c;
      repeat (4) @(posedge ref_clk);
      op(1'h1, 1'h0, 1'h0, 1'h1);
      chk(dOut, 8'h3c);
      chk(bOut, 8'h87);
      chk({7'h00, bOeN}, 8'h01);
      enN <= 1'h0;
      repeat (4) @(posedge ref_clk);
      op(1'h1, 1'h0, 1'h1, 1'h1);
      chk(bOut, 8'h3c);
      chk(dOut, 8'h87);
   endtask
   task automatic write_back;
      op(1'h1, 1'h1, 1'h0, 1'h1);
      chk({7'h00, dOeN}, 8'h00);
      chk(dPin, 8'h87);
      chk(bOut, 8'h3c);
      op(1'h0, 1'h0, 1'h0, 1'h0);
      chk({7'h00, dOeN}, 8'h01);
      chk(dPin, 8'h96);
   endtask
   // ==========================
   // Main sequence
   initial begin
      repeat (20) @(posedge ref_clk);
      arst_n <= 1'h1;
      repeat (3) @(posedge ref_clk);
      hold_and_load();
      shift_in();
      load_and_shift();
      copy_out();
      capture_and_swap();
      write_back();
      finalReport();
   end
endmodule
`default_nettype wire
